// ==== bench/crl_slave_phase.sv ====
`timescale 1ns/1ns
// ------------------------------------------------------------
// Slave phase controller model
// ------------------------------------------------------------
// Follows the master's switching and parks both gates while disabled.
// Combinational, so any parking delay in the design shows at once.
module crl_slave_phase (
   input  wire logic driver_disable_out,
   input  wire logic pwm_in,
   output logic      slave_high_gate,
   output logic      slave_low_gate
);
   assign slave_high_gate = driver_disable_out & pwm_in;
   assign slave_low_gate  = driver_disable_out & ~pwm_in;
endmodule : crl_slave_phase

// ==== bench/test_core_regulator_low_power_mode_control.sv ====
`timescale 1ns/1ns
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
   $display("mismatch %s expected %h seen %h", nm, e, s); end end
module test_core_regulator_low_power_mode_control
   import crl_pkg::*;
;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, deep_sleep_n = 1, suspend_request = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic [5:0]  vid_code = 6'h15, suspend_voltage_select = 6'h0a, target_code;
   logic slew_at_final = 0, supply_ok_good = 0, error_comp_low = 0, on_time_done = 0;
   logic [7:0]  valley_mv = 0, reverse_mv = 0, switch_node_mv = 0, lim;
   logic low_side_sensed_off = 1, hready, hresp, offset_enable, driver_disable_out;
   logic pulse_frequency_mode, core_power_good, cpu_clock_enable_n;
   logic high_side_gate, low_side_gate, slave_high_gate, slave_low_gate;
   logic [7:0]  adj_tab [4] = '{8'h28, 8'h05, 8'h64, 8'hc8};
   int          failures = 0, checked = 0, n;

   always #20 hclk = ~hclk;

   crl_mode_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .deep_sleep_n(deep_sleep_n),
      .suspend_request(suspend_request), .vid_code(vid_code),
      .suspend_voltage_select(suspend_voltage_select), .slew_at_final(slew_at_final),
      .supply_ok_good(supply_ok_good), .error_comp_low(error_comp_low),
      .on_time_done(on_time_done), .valley_mv(valley_mv), .reverse_mv(reverse_mv),
      .switch_node_mv(switch_node_mv), .low_side_sensed_off(low_side_sensed_off),
      .target_code(target_code), .offset_enable(offset_enable),
      .driver_disable_out(driver_disable_out), .pulse_frequency_mode(pulse_frequency_mode),
      .core_power_good(core_power_good), .cpu_clock_enable_n(cpu_clock_enable_n),
      .high_side_gate(high_side_gate), .low_side_gate(low_side_gate));

   crl_slave_phase i_slave (.driver_disable_out(driver_disable_out), .pwm_in(high_side_gate),
      .slave_high_gate(slave_high_gate), .slave_low_gate(slave_low_gate));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic finish_test();
      if (failures == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : finish_test

   task automatic step(input int k);
      repeat (k) @(posedge hclk);
      #1;
   endtask : step

   // Single word transfer; waits on hready, never on a fixed count
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int m;
      @(posedge hclk);
      hsel <= 1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w; hsize <= 3'h2;
      m = 0;
      do begin @(posedge hclk); m++; end while (hready !== 1'b1 && m < 50);
      hsel <= 0; htrans <= 2'h0; hwdata <= d;
      do begin @(posedge hclk); m++; end while (hready !== 1'b1 && m < 100);
      rd = hrdata;
      `CHK("hresp", 1'b0, hresp)
      if (m >= 100) begin failures++; finish_test(); end
   endtask : bus

   // Cycles until driver disable (k=0) or skip mode (k=1) reaches v
   task automatic wait_sig(input int k, input logic v);
      n = 0;
      do begin step(1); n++; end
      while (((k == 0) ? driver_disable_out : pulse_frequency_mode) !== v && n < 400);
      if (n >= 400) begin failures++; finish_test(); end
   endtask : wait_sig

   // Tick = 2 clocks once the divider is 1; one tick of slack early, two ticks late
   function automatic logic near(input int c, input int t);
      return (c >= 2 * t - 2 && c <= 2 * t + 4);
   endfunction : near

   function automatic logic [7:0] exp_lim(input logic tied, input logic [7:0] a);
      if (tied) return LIMIT_DEFAULT_MV;
      return (a < LIMIT_MIN_MV) ? LIMIT_MIN_MV : (a > LIMIT_MAX_MV) ? LIMIT_MAX_MV : a;
   endfunction : exp_lim

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(91));
      repeat (16) @(posedge hclk);
      hresetn <= 1;
      step(1);
      `CHK("ddo_reset", 1'b1, driver_disable_out)
      `CHK("pfm_reset", 1'b0, pulse_frequency_mode)
      `CHK("cpu_clock_enable_n_reset", 1'b1, cpu_clock_enable_n)
      bus(0, ADDR_SLEW, 0);
      `CHK("slew_div_reset", SLEW_DIV_RESET, rd[15:0])
      bus(0, 8'h40, 0);
      `CHK("unmapped_read", 32'h0, rd)
      bus(1, ADDR_SLEW, 32'h1);
      for (int i = 0; i < 4; i++) begin
         bus(1, ADDR_CTRL, {30'h0, i == 0, i != 0});
         bus(1, ADDR_LIMIT, {24'h0, adj_tab[i]});
         bus(0, ADDR_LIMIT, 0);
         lim = exp_lim(i == 0, adj_tab[i]);
         `CHK("limit", lim, rd[7:0])
         `CHK("neg_limit", lim + lim / 5, rd[15:8])
      end
      repeat (200) begin
         step(1);
         error_comp_low <= 1'($urandom); on_time_done <= 1'($urandom);
         low_side_sensed_off <= 1'($urandom); valley_mv <= 8'($urandom);
         reverse_mv <= 8'($urandom); switch_node_mv <= 8'($urandom);
         `CHK("gate_overlap", 1'b0, high_side_gate & low_side_gate)
      end
      // One full pulse first clears any truncation left over from the random phase
      valley_mv <= 0; error_comp_low <= 1; on_time_done <= 0; low_side_sensed_off <= 1;
      reverse_mv <= 0; switch_node_mv <= 8'h40;
      step(16);
      `CHK("hs_starts", 1'b1, high_side_gate)
      // Valley current above the limit blocks every new on-time
      valley_mv <= 8'hff; on_time_done <= 1;
      step(12);
      repeat (30) begin
         step(1);
         `CHK("hs_blocked", 1'b0, high_side_gate)
         `CHK("ls_complement", 1'b1, low_side_gate)
      end
      // Early return from deep sleep abandons the pending count
      vid_code <= 6'($urandom); deep_sleep_n <= 0; step(20);
      deep_sleep_n <= 1; step(4);
      deep_sleep_n <= 0;
      step(8);
      `CHK("edge_pg_forced", 1'b1, core_power_good)
      `CHK("edge_cpu_clock_enable_n_forced", 1'b0, cpu_clock_enable_n)
      `CHK("offset_on", 1'b1, offset_enable)
      wait_sig(0, 1'b0);
      `CHK("ddo_sleep_delay", 1'b1, near(n + 8, 32))
      `CHK("slave_parked", 2'b00, {slave_high_gate, slave_low_gate})
      wait_sig(1, 1'b1);
      `CHK("pfm_sleep_delay", 1'b1, near(n, 30))
      `CHK("pg_unforced", 1'b0, core_power_good)
      error_comp_low <= 0; valley_mv <= 0; switch_node_mv <= 8'h00;
      step(6);
      repeat (20) begin
         step(1);
         `CHK("skip_ls_truncated", 1'b0, low_side_gate)
      end
      deep_sleep_n <= 1;
      step(3);
      `CHK("sleep_exit", 3'b100, {driver_disable_out, pulse_frequency_mode, offset_enable})
      `CHK("sleep_exit_target", vid_code, target_code)
      // Suspend: blanking waits on the final code, then 32 ticks
      supply_ok_good <= 1; suspend_voltage_select <= 6'($urandom); step(80);
      suspend_request <= 1;
      step(3);
      supply_ok_good <= 0;
      `CHK("sus_target", suspend_voltage_select, target_code)
      step(100);
      `CHK("sus_ddo_waits_final", 1'b1, driver_disable_out)
      `CHK("sus_pg_blanked", 1'b1, core_power_good)
      `CHK("sus_cpu_clock_enable_n_blanked", 1'b0, cpu_clock_enable_n)
      slew_at_final <= 1;
      wait_sig(0, 1'b0);
      `CHK("ddo_sus_delay", 1'b1, near(n, 32))
      wait_sig(1, 1'b1);
      `CHK("pfm_sus_delay", 1'b1, near(n, 30))
      suspend_request <= 0; slew_at_final <= 0;
      step(3);
      `CHK("sus_exit", 2'b10, {driver_disable_out, pulse_frequency_mode})
      `CHK("sus_exit_target", vid_code, target_code)
      finish_test();
   end
endmodule : test_core_regulator_low_power_mode_control

// ==== verilog/crl_gate_drive.sv ====
`timescale 1ns/1ns
// Gate sequencing: on-time start gating, dead times and zero-cross truncation.
module crl_gate_drive
   import crl_pkg::*;
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       skip_mode,
   input  wire logic       error_comp_low,
   input  wire logic       on_time_done,
   input  wire logic [7:0] valley_mv,
   input  wire logic [7:0] reverse_mv,
   input  wire logic [7:0] limit_mv,
   input  wire logic [7:0] neg_limit_mv,
   input  wire logic [7:0] switch_node_mv,
   input  wire logic       low_side_sensed_off,
   output logic            high_side_gate,
   output logic            low_side_gate
);
   logic [4:0] off_count;
   logic [1:0] dead_count;
   logic       truncated;

   wire off_done    = (off_count >= 5'(MIN_OFF_CYC));
   wire over_limit  = (valley_mv > limit_mv);
   wire neg_over    = (reverse_mv > neg_limit_mv);
   wire start_ok    = error_comp_low && !over_limit && off_done;
   wire start_pulse = !high_side_gate && start_ok && low_side_sensed_off && !low_side_gate;
   wire zero_cross  = skip_mode && (switch_node_mv < ZERO_CROSS_MV);
   wire dead_done   = (dead_count >= 2'(DEAD_HL_CYC));
   wire want_low    = !high_side_gate && dead_done && !truncated && !start_ok;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         high_side_gate <= 1'b0;
         low_side_gate  <= 1'b0;
         off_count      <= 5'h00;
         dead_count     <= 2'h0;
         truncated      <= 1'b0;
      end else begin
         if (high_side_gate) begin
            high_side_gate <= !on_time_done;
            off_count      <= 5'h00;
            dead_count     <= 2'h0;
            truncated      <= 1'b0;
         end else begin
            high_side_gate <= start_pulse;
            if (!off_done) off_count <= off_count + 5'h01;
            if (!dead_done) dead_count <= dead_count + 2'h1;
            if (zero_cross || neg_over) truncated <= 1'b1;
         end
         // Forced PWM keeps the low side as the complement after the dead time until reverse current passes the negative limit
         low_side_gate <= skip_mode ? (want_low && !zero_cross && !neg_over)
                                    : (want_low && !neg_over);
      end
   end

   AST_DEAD_TIME: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(high_side_gate) |-> !low_side_gate) else $error("low side on inside dead time");
   AST_NO_OVERLAP: assert property (@(posedge hclk) disable iff (!hresetn)
      !(high_side_gate && low_side_gate)) else $error("gates overlap");
   AST_LIMIT_BLOCK: assert property (@(posedge hclk) disable iff (!hresetn)
      (!high_side_gate && over_limit) |=> !$rose(high_side_gate)) else $error("start over limit");
   AST_SKIP_TRUNC: assert property (@(posedge hclk) disable iff (!hresetn)
      (skip_mode && zero_cross) |=> !low_side_gate) else $error("no zero-cross truncation");
endmodule : crl_gate_drive

// ==== verilog/crl_mode_ctrl.sv ====
`timescale 1ns/1ns
module crl_mode_ctrl
   import crl_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        deep_sleep_n,
   input  wire logic        suspend_request,
   input  wire logic [5:0]  vid_code,
   input  wire logic [5:0]  suspend_voltage_select,
   input  wire logic        slew_at_final,
   input  wire logic        supply_ok_good,
   input  wire logic        error_comp_low,
   input  wire logic        on_time_done,
   input  wire logic [7:0]  valley_mv,
   input  wire logic [7:0]  reverse_mv,
   input  wire logic [7:0]  switch_node_mv,
   input  wire logic        low_side_sensed_off,
   output logic [5:0]       target_code,
   output logic             offset_enable,
   output logic             driver_disable_out,
   output logic             pulse_frequency_mode,
   output logic             core_power_good,
   output logic             cpu_clock_enable_n,
   output logic             high_side_gate,
   output logic             low_side_gate
);
   // ------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------
   logic [1:0]  ctrl;
   logic [7:0]  adjust_mv;
   logic [15:0] slew_div;
   logic        wr_pend;
   logic [7:0]  wr_addr;
   logic [7:0]  limit_mv;
   logic [7:0]  neg_limit_mv;
   crl_mode_t   mode;
   crl_mode_t   next_mode;

   wire       bus_take  = hsel && hready && htrans[1];
   wire [7:0] rd_addr   = haddr[7:0];
   // Ten percent scaling of the divider voltage is done by software writing mV/10 * 10
   wire [7:0] adj_clamp = (adjust_mv < LIMIT_MIN_MV) ? LIMIT_MIN_MV :
                          (adjust_mv > LIMIT_MAX_MV) ? LIMIT_MAX_MV : adjust_mv;
   wire [7:0] next_limit = ctrl[CTRL_TIED_BIT] ? LIMIT_DEFAULT_MV : adj_clamp;
   // 120 percent: x + x/5, saturating to stay in eight bits
   wire [8:0] neg_sum    = {1'b0, next_limit} + {1'b0, next_limit / 8'd5};
   wire [7:0] next_neg   = neg_sum[8] ? 8'hff : neg_sum[7:0];
   wire [31:0] rd_mux =
      (rd_addr == ADDR_CTRL)   ? {30'h0, ctrl} :
      (rd_addr == ADDR_STATUS) ? {22'h0, mode, pulse_frequency_mode, driver_disable_out,
                                  core_power_good, cpu_clock_enable_n,
                                  high_side_gate, low_side_gate, offset_enable} :
      (rd_addr == ADDR_LIMIT)  ? {16'h0, neg_limit_mv, limit_mv} :
      (rd_addr == ADDR_SLEW)   ? {16'h0, slew_div} :
      (rd_addr == ADDR_TARGET) ? {26'h0, target_code} : BUS_OKAY_ZERO;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend   <= 1'b0;
         wr_addr   <= 8'h00;
         hrdata    <= BUS_OKAY_ZERO;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend <= bus_take && hwrite;
         wr_addr <= rd_addr;
         if (bus_take && !hwrite) hrdata <= rd_mux;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl      <= CTRL_RESET;
         adjust_mv <= ADJ_RESET;
         slew_div  <= SLEW_DIV_RESET;
      end else if (wr_pend) begin
         if (wr_addr == ADDR_CTRL) ctrl <= hwdata[1:0];
         if (wr_addr == ADDR_LIMIT) adjust_mv <= hwdata[7:0];
         if (wr_addr == ADDR_SLEW) slew_div <= hwdata[15:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         limit_mv     <= LIMIT_DEFAULT_MV;
         neg_limit_mv <= LIMIT_DEFAULT_MV;
      end else begin
         limit_mv     <= next_limit;
         neg_limit_mv <= next_neg;
      end
   end

   // ------------------------------------------------------------
   // Slew timer clock divider
   // ------------------------------------------------------------
   logic [15:0] div_count;
   logic        tick;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_count <= 16'h0000;
         tick      <= 1'b0;
      end else if (div_count >= slew_div) begin
         div_count <= 16'h0000;
         tick      <= 1'b1;
      end else begin
         div_count <= div_count + 16'h0001;
         tick      <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Mode sequencer
   // ------------------------------------------------------------
   logic dslp_q;
   logic sus_q;
   logic seq_done;
   logic blank_done;
   logic blank_on;
   logic blank_wait_final;

   wire  dslp_edge = dslp_q != deep_sleep_n;
   wire  sus_edge  = sus_q != suspend_request;
   wire  any_edge  = dslp_edge || sus_edge;
   wire  seq_run   = (mode == CRL_SLP_WAIT) || (mode == CRL_SLP_PARK) ||
                     (mode == CRL_SUS_WAIT) || (mode == CRL_SUS_PARK);
   wire  park_lim  = (mode == CRL_SLP_PARK) || (mode == CRL_SUS_PARK);
   wire [5:0] seq_limit = park_lim ? SKIP_DELAY_TICKS : DDO_DELAY_TICKS;
   wire  seq_restart = any_edge || (mode != next_mode);

   crl_tick_count u_seq_count (
      .hclk    (hclk),
      .hresetn (hresetn),
      .restart (seq_restart),
      .run     (seq_run),
      .tick    (tick),
      .limit   (seq_limit),
      .done    (seq_done)
   );

   always_comb begin
      next_mode = mode;
      if (suspend_request) begin
         unique case (mode)
            CRL_SUS_SLEW: if (slew_at_final) next_mode = CRL_SUS_WAIT;
            CRL_SUS_WAIT: if (seq_done) next_mode = CRL_SUS_PARK;
            CRL_SUS_PARK: if (seq_done) next_mode = CRL_SKIP;
            CRL_SKIP:     if (sus_edge) next_mode = CRL_SUS_SLEW;
            default:      next_mode = CRL_SUS_SLEW;
         endcase
      end else if (!deep_sleep_n) begin
         unique case (mode)
            CRL_SLP_WAIT: if (seq_done) next_mode = CRL_SLP_PARK;
            CRL_SLP_PARK: if (seq_done) next_mode = CRL_SKIP;
            CRL_SKIP:     if (any_edge) next_mode = CRL_SLP_WAIT;
            default:      next_mode = CRL_SLP_WAIT;
         endcase
      end else begin
         next_mode = CRL_PWM;
      end
   end

   // Blanking: deep-sleep edges count 32 ticks; suspend edges wait for final code first unless a deep-sleep edge comes in the same cycle
   wire blank_run = blank_on && !blank_wait_final;
   crl_tick_count u_blank_count (
      .hclk    (hclk),
      .hresetn (hresetn),
      .restart (any_edge),
      .run     (blank_run),
      .tick    (tick),
      .limit   (BLANK_TICKS),
      .done    (blank_done)
   );

   wire skip_now = (next_mode == CRL_SKIP);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode                 <= CRL_PWM;
         dslp_q               <= 1'b1;
         sus_q                <= 1'b0;
         blank_on             <= 1'b0;
         blank_wait_final     <= 1'b0;
         driver_disable_out   <= 1'b1;
         pulse_frequency_mode <= 1'b0;
         offset_enable        <= 1'b0;
         target_code          <= 6'h00;
         core_power_good      <= 1'b0;
         cpu_clock_enable_n   <= 1'b1;
      end else begin
         mode   <= next_mode;
         dslp_q <= deep_sleep_n;
         sus_q  <= suspend_request;
         // Driver disable is low only in the park and skip states
         driver_disable_out   <= !((next_mode == CRL_SLP_PARK) || (next_mode == CRL_SUS_PARK)
                                   || skip_now);
         pulse_frequency_mode <= skip_now;
         offset_enable        <= !deep_sleep_n && !suspend_request;
         target_code          <= suspend_request ? suspend_voltage_select : vid_code;
         if (dslp_edge) begin
            blank_on         <= 1'b1;
            blank_wait_final <= 1'b0;
         end else if (sus_edge) begin
            blank_on         <= 1'b1;
            blank_wait_final <= 1'b1;
         end else if (blank_wait_final && slew_at_final) begin
            blank_wait_final <= 1'b0;
         end else if (blank_done) begin
            blank_on <= 1'b0;
         end
         // Blanking forces good state; otherwise follow the supply status
         core_power_good    <= (blank_on || any_edge) ? 1'b1 : supply_ok_good;
         cpu_clock_enable_n <= (blank_on || any_edge) ? 1'b0 : !supply_ok_good;
      end
   end

   crl_gate_drive u_gate (
      .hclk                (hclk),
      .hresetn             (hresetn),
      .skip_mode           (pulse_frequency_mode),
      .error_comp_low      (error_comp_low),
      .on_time_done        (on_time_done),
      .valley_mv           (valley_mv),
      .reverse_mv          (reverse_mv),
      .limit_mv            (limit_mv),
      .neg_limit_mv        (neg_limit_mv),
      .switch_node_mv      (switch_node_mv),
      .low_side_sensed_off (low_side_sensed_off),
      .high_side_gate      (high_side_gate),
      .low_side_gate       (low_side_gate)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_sleep_exit;
      $rose(deep_sleep_n) && !suspend_request;
   endsequence

   sequence s_sus_exit;
      $fell(suspend_request) && deep_sleep_n;
   endsequence

   AST_EXIT_FAST: assert property (@(posedge hclk) disable iff (!hresetn)
      s_sleep_exit |=> driver_disable_out && !pulse_frequency_mode)
      else $error("deep sleep exit not immediate");
   AST_SUS_EXIT: assert property (@(posedge hclk) disable iff (!hresetn)
      s_sus_exit |=> driver_disable_out && target_code == $past(vid_code))
      else $error("suspend exit not immediate");
   AST_BLANK_DSLP: assert property (@(posedge hclk) disable iff (!hresetn)
      dslp_edge |=> core_power_good && !cpu_clock_enable_n)
      else $error("deep sleep edge not blanked");
   AST_SKIP_NEEDS_DDO: assert property (@(posedge hclk) disable iff (!hresetn)
      pulse_frequency_mode |-> !driver_disable_out)
      else $error("skip with driver enabled");
   AST_SUS_TARGET: assert property (@(posedge hclk) disable iff (!hresetn)
      (suspend_request && $past(suspend_request)) |-> target_code == $past(suspend_voltage_select))
      else $error("suspend target wrong");
   AST_NEG_TRACK: assert property (@(posedge hclk) disable iff (!hresetn)
      neg_limit_mv >= limit_mv) else $error("negative limit below positive");
   AST_LIMIT_RANGE: assert property (@(posedge hclk) disable iff (!hresetn)
      limit_mv >= LIMIT_MIN_MV && limit_mv <= LIMIT_MAX_MV) else $error("limit out of range");
   AST_SUS_BLANK: assert property (@(posedge hclk) disable iff (!hresetn)
      sus_edge |=> core_power_good && !cpu_clock_enable_n)
      else $error("suspend edge not blanked");
   AST_SUS_HOLD_DDO: assert property (@(posedge hclk) disable iff (!hresetn)
      (mode == CRL_SUS_SLEW) |-> driver_disable_out)
      else $error("driver disabled before final code");
   AST_SLEEP_OFFSET: assert property (@(posedge hclk) disable iff (!hresetn)
      (!deep_sleep_n && !suspend_request) |=> offset_enable)
      else $error("deep sleep offset missing");
endmodule : crl_mode_ctrl

// ==== verilog/crl_pkg.sv ====
package crl_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_STATUS   = 8'h04;
   localparam logic [7:0]  ADDR_LIMIT    = 8'h08;
   localparam logic [7:0]  ADDR_SLEW     = 8'h0c;
   localparam logic [7:0]  ADDR_TARGET   = 8'h10;
   localparam int          CTRL_ADJ_BIT  = 0;
   localparam int          CTRL_TIED_BIT = 1;
   localparam logic [1:0]  CTRL_RESET    = 2'h0;
   localparam logic [7:0]  ADJ_RESET     = 8'h00;
   localparam logic [15:0] SLEW_DIV_RESET = 16'h0019;
   localparam logic [31:0] BUS_OKAY_ZERO = 32'h0000_0000;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam logic [5:0]  DDO_DELAY_TICKS  = 6'h20;
   localparam logic [5:0]  SKIP_DELAY_TICKS = 6'h1e;
   localparam logic [5:0]  BLANK_TICKS      = 6'h20;
   localparam int          CLK_NS       = 40;
   localparam int          MIN_OFF_NS   = 400;
   localparam int          DEAD_HL_NS   = 35;
   localparam int          MIN_OFF_CYC  = (MIN_OFF_NS + CLK_NS - 1) / CLK_NS;
   localparam int          DEAD_HL_CYC  = (DEAD_HL_NS + CLK_NS - 1) / CLK_NS;

   // ------------------------------------------------------------
   // Current limit, in 1 mV units
   // ------------------------------------------------------------
   localparam logic [7:0]  LIMIT_MIN_MV     = 8'h0a;
   localparam logic [7:0]  LIMIT_MAX_MV     = 8'h96;
   localparam logic [7:0]  LIMIT_DEFAULT_MV = 8'h32;
   localparam logic [7:0]  ZERO_CROSS_MV    = 8'h04;

   typedef enum logic [2:0] {
      CRL_PWM       = 3'b000,
      CRL_SLP_WAIT  = 3'b001,
      CRL_SLP_PARK  = 3'b010,
      CRL_SUS_SLEW  = 3'b011,
      CRL_SUS_WAIT  = 3'b100,
      CRL_SUS_PARK  = 3'b101,
      CRL_SKIP      = 3'b110
   } crl_mode_t;
endpackage : crl_pkg

// ==== verilog/crl_tick_count.sv ====
`timescale 1ns/1ns
// Counts slew timer ticks from a restart; done when the count reaches limit.
module crl_tick_count
   import crl_pkg::*;
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       restart,
   input  wire logic       run,
   input  wire logic       tick,
   input  wire logic [5:0] limit,
   output logic            done
);
   logic [5:0] count;

   assign done = run && (count == limit);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= 6'h00;
      end else if (restart || !run) begin
         count <= 6'h00;
      end else if (tick && !done) begin
         count <= count + 6'h01;
      end
   end
endmodule : crl_tick_count
